// ### plp_params.svh
// Register offsets, field positions, reset values and timing counts of the loop programming block
`ifndef PLP_PARAMS_SVH
`define PLP_PARAMS_SVH
`define PLP_OFS_CTRL     4'h0
`define PLP_OFS_BW       4'h4
`define PLP_OFS_PROG     4'h8
`define PLP_CTRL_IE      7
`define PLP_CTRL_FLAG    6
`define PLP_CTRL_PON     5
`define PLP_CTRL_BCS     4
`define PLP_BW_AUTO      7
`define PLP_BW_LOCK      6
`define PLP_BW_ACQ       5
`define PLP_RST_MUL      4'h6
`define PLP_RST_RANGE    4'h6
`define PLP_RST_PON      1'b1
`define PLP_CTRL_ONES    4'hF
`define PLP_WAIT_STATES  1
`endif

// ### plp_pkg.sv
// Types shared by the loop programming block
package plp_pkg;
    // Avalon-MM request from the bus master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } plp_avreq_type;

    // Avalon-MM answer to the bus master
    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } plp_avrsp_type;

    // Loop settings handed to the analog synthesizer
    typedef struct packed {
        logic       loopEnable;
        logic       baseClockSelect;
        logic [3:0] multiplier;
        logic [3:0] rangeMultiplier;
    } plp_loop_type;

    // Whole state of the block
    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
        logic        irqEnable;
        logic        lockFlag;
        logic        loopPower;
        logic        baseSel;
        logic        autoMode;
        logic        acqManual;
        logic [3:0]  feedbackRatio;
        logic [3:0]  vcoRange;
        logic [2:0]  lockSync;
        logic        lockStable;
        logic [2:0]  trackSync;
        logic        trackStable;
        logic        irq;
        plp_loop_type loopOut;
    } plp_state_type;
endpackage : plp_pkg

// ### plp_loop_prog.sv
// Loop programming register, base clock select protection and lock-change interrupt
//
// Summary of operation
// RULE1 - Feedback ratio code gives multiplier; 0,1 give 1
// RULE2 - Feedback ratio resets to six
// RULE3 - Feedback ratio writes blocked while loop powered
// RULE4 - VCO range writes blocked while loop powered
// RULE5 - Zero range disables loop, clears base select
// RULE6 - Zero range refuses setting base select
// RULE7 - VCO range resets to six
// RULE8 - Automatic mode: every lock change raises request
// RULE9 - Interrupt forwarded only with enable set
// RULE10 - Flag set on change regardless of enable
// RULE11 - Manual mode: no interrupts, flag reads zero
// RULE12 - Software reads lock bit to find cause
// RULE13 - Base select accepted even when unlocked
// RULE14 - Software should check lock before selecting
// RULE15 - Wait state leaves clock generator untouched
// RULE16 - Automatic mode: tracking flag when acquisition done
// RULE17 - Automatic mode: lock bit when within tolerance
// RULE18 - Control register read clears flag; reset too
// RULE19 - No power-off under base select; no select unpowered
// RULE20 - Lock bit read-only; zero in manual mode
// RULE21 - Blocked writes complete normally, contents unchanged
//
// Register map, one byte per word in the low byte
//   0x0 control:     7 irq enable, 6 lock-change flag, 5 loop power, 4 base select, 3:0 read ones
//   0x4 bandwidth:   7 automatic mode, 6 lock (read only), 5 tracking, 4:0 read zero
//   0x8 programming: 7:4 feedback ratio, 3:0 VCO range
//   Other offsets read zero and ignore writes
//
// Bus timing
//   Every request sees exactly one wait state: waitrequest drops in the cycle
//   after the request appears and the access is taken at the next edge.
//   Read data are latched in the wait cycle, so they stand at the taking edge.
//
// Hazards and limits
//   Lock and tracking levels come from the analog loop with no clock relation,
//   so each passes three flops; a pulse shorter than two cycles may be lost.
//   A lock change and a control read in one cycle keep the flag set; software
//   sees it on its next read. A change in the read's wait cycle is cleared unread.
//   Selecting the VCO clock from power-off takes two control writes: the
//   select bit is honoured only when the loop was already powered.
//   There is no wait-mode input on purpose; the loop keeps its settings.
//   The crystal-loss indication is not built; that bit reads zero.
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "plp_params.svh"

module plp_loop_prog (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire plp_pkg::plp_avreq_type avReq,
    output plp_pkg::plp_avrsp_type      avRsp,
    input  wire logic                   lockDetect,
    input  wire logic                   trackDetect,
    output plp_pkg::plp_loop_type       loopCtrl,
    output logic                        irq
);
    import plp_pkg::*;

    // Multiplier seen by the feedback divider
    function automatic logic [3:0] ratio_to_mult(input logic [3:0] code);
        ratio_to_mult = (code < 4'h2) ? 4'h1 : code; // RULE1
    endfunction : ratio_to_mult

    // Register select for one address
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    plp_state_type st;      // Present state
    plp_state_type next_st; // Next state

    // Handshake terms
    logic accRd;   // Read taken at this edge
    logic accWr;   // Write taken at this edge
    logic lockChg; // Debounced lock level changed
    logic rangeOk; // Range field not all zeros

    // Next state of every flop
    always_comb begin
        next_st = st;
        accRd   = avReq.read && !st.waitreq;
        accWr   = avReq.write && !st.waitreq;

        // Waitrequest drops one cycle after a request shows up
        next_st.waitreq = !((avReq.read || avReq.write) && st.waitreq); // RULE21

        // Pin synchronisers, three stages each
        next_st.lockSync  = {st.lockSync[1:0], lockDetect};
        next_st.trackSync = {st.trackSync[1:0], trackDetect};
        // A level counts once stages two and three agree
        if (st.lockSync[1] == st.lockSync[2]) begin
            next_st.lockStable = st.lockSync[2]; // RULE17
        end
        if (st.trackSync[1] == st.trackSync[2]) begin
            next_st.trackStable = st.trackSync[2]; // RULE16
        end
        lockChg = (st.lockSync[1] == st.lockSync[2]) && (st.lockSync[2] != st.lockStable);

        // Register writes
        if (accWr && hit(avReq.address, `PLP_OFS_CTRL)) begin
            // Interrupt enable only writable in automatic mode
            next_st.irqEnable = avReq.writedata[`PLP_CTRL_IE] && st.autoMode;
            // Power stays on while the VCO drives the base clock
            next_st.loopPower = avReq.writedata[`PLP_CTRL_PON] || st.baseSel; // RULE19
            // Select needs power and a nonzero range; lock not needed
            // A write that drops power cannot raise select in the same cycle
            next_st.baseSel = avReq.writedata[`PLP_CTRL_BCS] && st.loopPower && next_st.loopPower; // RULE19 RULE13
        end
        if (accWr && hit(avReq.address, `PLP_OFS_BW)) begin
            next_st.autoMode = avReq.writedata[`PLP_BW_AUTO];
            // Manual value is kept aside while automatic mode runs
            if (!st.autoMode) begin
                next_st.acqManual = avReq.writedata[`PLP_BW_ACQ];
            end
        end
        // Programming fields frozen while the loop is powered
        if (accWr && hit(avReq.address, `PLP_OFS_PROG) && !st.loopPower) begin
            next_st.feedbackRatio = avReq.writedata[7:4]; // RULE3
            next_st.vcoRange      = avReq.writedata[3:0]; // RULE4
        end

        // Zero range forces the base select clear at all times
        rangeOk = (next_st.vcoRange != 4'h0);
        if (!rangeOk) begin
            next_st.baseSel = 1'b0; // RULE5 RULE6
        end
        // Manual mode forces the enable low
        if (!next_st.autoMode) begin
            next_st.irqEnable = 1'b0; // RULE11
        end

        // Lock-change flag: set wins over the read clear
        if (st.autoMode && lockChg) begin
            next_st.lockFlag = 1'b1; // RULE8 RULE10
        end else if (!st.autoMode) begin
            next_st.lockFlag = 1'b0; // RULE11
        end else if (accRd && hit(avReq.address, `PLP_OFS_CTRL)) begin
            next_st.lockFlag = 1'b0; // RULE18
        end

        // Read data prepared in the cycle before the read is taken
        next_st.rdata = 32'h0000_0000;
        if (avReq.read && st.waitreq) begin
            case (avReq.address)
                `PLP_OFS_CTRL: begin
                    next_st.rdata[`PLP_CTRL_IE]   = st.irqEnable;
                    next_st.rdata[`PLP_CTRL_FLAG] = st.lockFlag && st.autoMode; // RULE11
                    next_st.rdata[`PLP_CTRL_PON]  = st.loopPower;
                    next_st.rdata[`PLP_CTRL_BCS]  = st.baseSel;
                    next_st.rdata[3:0]            = `PLP_CTRL_ONES;
                end
                `PLP_OFS_BW: begin
                    next_st.rdata[`PLP_BW_AUTO] = st.autoMode;
                    next_st.rdata[`PLP_BW_LOCK] = st.autoMode && st.lockStable; // RULE20
                    next_st.rdata[`PLP_BW_ACQ]  = st.autoMode ? st.trackStable : st.acqManual; // RULE16
                end
                `PLP_OFS_PROG: begin
                    // Blocked writes leave these bits as they were
                    next_st.rdata[7:0] = {st.feedbackRatio, st.vcoRange}; // RULE21
                end
                default: begin
                    // Unmapped addresses read zero
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end else begin
            next_st.rdata = st.rdata;
        end

        // Interrupt only with automatic mode and enable
        next_st.irq = next_st.lockFlag && next_st.irqEnable && next_st.autoMode; // RULE9 RULE11

        // Loop outputs; no wait-mode input, so wait never alters them
        next_st.loopOut.loopEnable      = next_st.loopPower && rangeOk; // RULE5 RULE15
        next_st.loopOut.baseClockSelect = next_st.baseSel;
        next_st.loopOut.multiplier      = ratio_to_mult(next_st.feedbackRatio); // RULE1
        next_st.loopOut.rangeMultiplier = next_st.vcoRange;
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st                          <= '0;
            st.waitreq                  <= 1'b1;
            st.loopPower                <= `PLP_RST_PON;
            st.feedbackRatio            <= `PLP_RST_MUL;   // RULE2
            st.vcoRange                 <= `PLP_RST_RANGE; // RULE7
            st.loopOut.loopEnable       <= `PLP_RST_PON;
            st.loopOut.multiplier       <= `PLP_RST_MUL;
            st.loopOut.rangeMultiplier  <= `PLP_RST_RANGE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign avRsp.waitrequest = st.waitreq;
    assign avRsp.readdata    = st.rdata;
    assign loopCtrl          = st.loopOut;
    assign irq               = st.irq;

    // Checks kept beside the logic
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic progWrBlocked; // Write to programming register while powered
    assign progWrBlocked = accWr && hit(avReq.address, `PLP_OFS_PROG) && st.loopPower;
    logic progWrOpen; // Write to programming register while unpowered
    assign progWrOpen = accWr && hit(avReq.address, `PLP_OFS_PROG) && !st.loopPower;

    // Reads in their wait cycle; the data stand one cycle later
    logic rdCtrl; // Control read being prepared
    logic rdBw;   // Bandwidth read being prepared
    logic rdProg; // Programming read being prepared
    assign rdCtrl = avReq.read && st.waitreq && hit(avReq.address, `PLP_OFS_CTRL);
    assign rdBw   = avReq.read && st.waitreq && hit(avReq.address, `PLP_OFS_BW);
    assign rdProg = avReq.read && st.waitreq && hit(avReq.address, `PLP_OFS_PROG);

    a_mul_frozen: assert property (progWrBlocked |=> $stable(st.feedbackRatio)) // RULE3
        else $error("feedback ratio changed while loop powered");
    a_range_frozen: assert property (progWrBlocked |=> $stable(st.vcoRange)) // RULE4
        else $error("vco range changed while loop powered");
    a_zero_range: assert property (st.vcoRange == 4'h0 |-> !loopCtrl.baseClockSelect && !loopCtrl.loopEnable) // RULE5
        else $error("zero range left loop or base select active");
    a_mult_map: assert property (loopCtrl.multiplier == ((st.feedbackRatio < 4'h2) ? 4'h1 : st.feedbackRatio)) // RULE1
        else $error("multiplier does not follow ratio code");
    a_flag_on_change: assert property (st.autoMode && lockChg |=> st.lockFlag) // RULE10
        else $error("lock change did not set flag");
    a_irq_gate: assert property (irq |-> st.irqEnable && st.lockFlag && st.autoMode) // RULE9
        else $error("interrupt without enable and flag");
    a_manual_quiet: assert property (!st.autoMode |=> !irq && !st.lockFlag) // RULE11
        else $error("manual mode left interrupt or flag set");
    a_read_clears: assert property (accRd && hit(avReq.address, `PLP_OFS_CTRL) && !lockChg |=> !st.lockFlag) // RULE18
        else $error("control read did not clear flag");
    a_select_power: assert property (loopCtrl.baseClockSelect |-> st.loopPower) // RULE19
        else $error("base select without loop power");
    a_one_wait: assert property ((avReq.read || avReq.write) && st.waitreq |=> !avRsp.waitrequest ##1 avRsp.waitrequest) // RULE21
        else $error("waitrequest did not pulse low for one cycle");
    a_lock_change_irq: assert property (st.autoMode && st.irqEnable && lockChg ##1 st.irqEnable |-> irq) // RULE8
        else $error("enabled lock change gave no interrupt");

    // Protection of the select and power pair, and the enable held low in manual mode

    // Power stays on under the VCO select
    a_power_under_sel: assert property (st.baseSel |-> st.loopPower) // RULE19
        else $error("base select held without loop power");

    // A zero range never leaves the select set
    a_zero_range_sel: assert property (st.vcoRange == 4'h0 |-> !st.baseSel) // RULE6
        else $error("base select set with zero range");

    // Select is taken even without lock when power and range allow it
    a_sel_unlocked: assert property (accWr && hit(avReq.address, `PLP_OFS_CTRL) // RULE13
        && avReq.writedata[`PLP_CTRL_BCS] && avReq.writedata[`PLP_CTRL_PON]
        && st.loopPower && st.vcoRange != 4'h0 |=> st.baseSel)
        else $error("base select refused although allowed");

    // Manual mode holds the enable low
    a_enable_manual: assert property (!st.autoMode |-> !st.irqEnable) // RULE11
        else $error("interrupt enable set in manual mode");

    // Register read-back

    // Flag reads zero in manual mode
    a_flag_reads_zero: assert property (rdCtrl && !st.autoMode |=> !avRsp.readdata[`PLP_CTRL_FLAG]) // RULE11
        else $error("flag read as one in manual mode");

    // Lock bit reads zero in manual mode
    a_lock_reads_zero: assert property (rdBw && !st.autoMode |=> !avRsp.readdata[`PLP_BW_LOCK]) // RULE20
        else $error("lock bit read as one in manual mode");

    // Lock bit follows the synchronised level in automatic mode
    a_lock_reads_sync: assert property (rdBw && st.autoMode // RULE20
        |=> avRsp.readdata[`PLP_BW_LOCK] == $past(st.lockStable))
        else $error("lock bit does not follow lock level");

    // Tracking bit follows the synchronised level in automatic mode
    a_track_reads: assert property (rdBw && st.autoMode // RULE16
        |=> avRsp.readdata[`PLP_BW_ACQ] == $past(st.trackStable))
        else $error("tracking bit does not follow tracking level");

    // Manual tracking value reads back as written
    a_track_manual: assert property (rdBw && !st.autoMode // RULE16
        |=> avRsp.readdata[`PLP_BW_ACQ] == $past(st.acqManual))
        else $error("manual tracking value lost");

    // Unused bandwidth bits read zero
    a_bw_low_zero: assert property (rdBw |=> avRsp.readdata[4:0] == 5'h00) // RULE20
        else $error("unused bandwidth bits not zero");

    // Unused control bits read ones
    a_ctrl_low_ones: assert property (rdCtrl |=> avRsp.readdata[3:0] == `PLP_CTRL_ONES) // RULE18
        else $error("unused control bits not ones");

    // Enable bit reads back
    a_enable_reads: assert property (rdCtrl |=> avRsp.readdata[`PLP_CTRL_IE] == $past(st.irqEnable)) // RULE9
        else $error("enable bit read back wrong");

    // Programming fields read back their held contents
    a_prog_reads_back: assert property (rdProg // RULE21
        |=> avRsp.readdata[7:0] == {$past(st.feedbackRatio), $past(st.vcoRange)})
        else $error("programming register read back wrong");

    // Upper read bits always zero
    a_upper_zero: assert property (avRsp.readdata[31:8] == 24'h000000) // RULE21
        else $error("upper read data bits not zero");

    // Programming writes and loop outputs

    // Ratio write lands while unpowered
    a_ratio_lands: assert property (progWrOpen |=> st.feedbackRatio == $past(avReq.writedata[7:4])) // RULE3
        else $error("feedback ratio write lost while unpowered");

    // Range write lands while unpowered
    a_range_lands: assert property (progWrOpen |=> st.vcoRange == $past(avReq.writedata[3:0])) // RULE4
        else $error("vco range write lost while unpowered");

    // Loop runs only with power and a nonzero range
    a_enable_out: assert property (loopCtrl.loopEnable == (st.loopPower && st.vcoRange != 4'h0)) // RULE5
        else $error("loop enable output wrong");

    // Select output follows the register bit only
    a_select_out: assert property (loopCtrl.baseClockSelect == st.baseSel) // RULE15
        else $error("base select output wrong");

    // Multiplier never zero
    a_mult_nonzero: assert property (loopCtrl.multiplier != 4'h0) // RULE1
        else $error("multiplier output zero");

    // Range output follows the field
    a_range_out: assert property (loopCtrl.rangeMultiplier == st.vcoRange) // RULE4
        else $error("range output does not follow field");

    // Interrupt and handshake

    // Enabled flag drives the interrupt
    a_irq_follows: assert property (st.lockFlag && st.irqEnable && st.autoMode |-> irq) // RULE9
        else $error("enabled flag gave no interrupt");

    // Flag is set with the enable low, and no interrupt follows
    a_flag_no_enable: assert property (st.autoMode && !st.irqEnable && lockChg && !accWr // RULE10
        |=> st.lockFlag && !irq)
        else $error("disabled lock change handled wrong");

    // Idle bus keeps waitrequest high
    a_wait_idle: assert property (!avReq.read && !avReq.write |=> avRsp.waitrequest) // RULE21
        else $error("waitrequest low without request");

    c_irq_raised: cover property (st.autoMode && lockChg ##1 irq);
    c_blocked_write: cover property (progWrBlocked);
    c_flag_unenabled: cover property (st.autoMode && lockChg && !st.irqEnable);
    c_select_vco: cover property (!loopCtrl.baseClockSelect ##1 loopCtrl.baseClockSelect);
    c_set_beats_clear: cover property (accRd && hit(avReq.address, `PLP_OFS_CTRL) && lockChg && st.autoMode);
endmodule : plp_loop_prog

// ### tb.sv
// Self-checking testbench of the loop programming block
`timescale 1ns/1ns

module tb;
    import plp_pkg::*;
    logic          clk_sys;       // 20 MHz system clock
    logic          rst_n;         // Active-low reset
    plp_avreq_type avReq;         // Bus request
    plp_avrsp_type avRsp;         // Bus answer
    logic          lockDetect;    // Lock level from the synthesizer
    logic          trackDetect;   // Tracking level from the synthesizer
    plp_loop_type  loopCtrl;      // Loop settings
    logic          irq;           // Interrupt request
    int            miscompares;   // Mismatches seen
    int            nCompared;     // Comparisons made
    int            cycles = 0;    // Cycles since start
    logic [7:0]    rd;            // Scratch read value

    plp_loop_prog DUT (.clk_sys(clk_sys), .rst_n(rst_n), .avReq(avReq), .avRsp(avRsp),
        .lockDetect(lockDetect), .trackDetect(trackDetect), .loopCtrl(loopCtrl), .irq(irq));

    // Clock: 50 ns period
    always #25 clk_sys = ~clk_sys;

    // Timeout: the whole run needs well under 3000 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            test_done();
        end
    end

    // Verdict and end of run
    task test_done();
        $display("compared %0d, mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done

    // Compare one byte
    task chk(input logic [7:0] got, input logic [7:0] exp);
        nCompared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One Avalon cycle; request held until waitrequest seen low, released after that edge
    task access(input logic wr, input logic [3:0] addr, input logic [7:0] wd, output logic [7:0] rdv);
        @(posedge clk_sys);
        avReq.read      <= !wr;
        avReq.write     <= wr;
        avReq.address   <= addr;
        avReq.writedata <= {24'h000000, wd};
        @(posedge clk_sys);
        while (avRsp.waitrequest !== 1'b0) @(posedge clk_sys);
        rdv = avRsp.readdata[7:0];
        avReq.read  <= 1'b0;
        avReq.write <= 1'b0;
    endtask : access

    task wr(input logic [3:0] addr, input logic [7:0] wd);
        access(1'b1, addr, wd, rd);
    endtask : wr

    task rdchk(input logic [3:0] addr, input logic [7:0] exp);
        access(1'b0, addr, 8'h00, rd);
        chk(rd, exp);
    endtask : rdchk

    // Let the lock pins pass the synchronizer
    task settle();
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    // Main sequence
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        avReq = '0;
        lockDetect = 1'b0;
        trackDetect = 1'b0;
        miscompares = 0;
        nCompared = 0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdchk(4'h0, 8'h2F);
        rdchk(4'h4, 8'h00);
        rdchk(4'h8, 8'h66);
        chk({loopCtrl.multiplier, loopCtrl.rangeMultiplier}, 8'h66);
        wr(4'hC, 8'hFF);
        rdchk(4'hC, 8'h00);
        $display("test reset done");
        wr(4'h8, 8'h12);
        rdchk(4'h8, 8'h66);
        wr(4'h0, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr(4'h8, {i[3:0], 4'h6});
            @(negedge clk_sys);
            chk({4'h0, loopCtrl.multiplier}, (i < 2) ? 8'h01 : 8'(i));
        end
        wr(4'h8, 8'h20);
        wr(4'h0, 8'h20);
        @(negedge clk_sys);
        chk({7'h00, loopCtrl.loopEnable}, 8'h00);
        wr(4'h0, 8'h30);
        rdchk(4'h0, 8'h2F);
        wr(4'h0, 8'h00);
        wr(4'h8, 8'h26);
        wr(4'h0, 8'h20);
        wr(4'h0, 8'h30);
        rdchk(4'h0, 8'h3F);
        chk({6'h00, loopCtrl.loopEnable, loopCtrl.baseClockSelect}, 8'h03);
        wr(4'h0, 8'h10);
        rdchk(4'h0, 8'h3F);
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h10);
        rdchk(4'h0, 8'h0F);
        wr(4'h0, 8'h20);
        $display("test protection done");
        @(posedge clk_sys);
        lockDetect <= 1'b1;
        settle();
        chk({7'h00, irq}, 8'h00);
        rdchk(4'h0, 8'h2F);
        rdchk(4'h4, 8'h00);
        wr(4'h4, 8'h80);
        rdchk(4'h4, 8'hC0);
        access(1'b0, 4'h0, 8'h00, rd);
        trackDetect <= 1'b1;
        settle();
        rdchk(4'h4, 8'hE0);
        @(posedge clk_sys);
        lockDetect <= 1'b0;
        settle();
        chk({7'h00, irq}, 8'h00);
        rdchk(4'h0, 8'h6F);
        rdchk(4'h0, 8'h2F);
        rdchk(4'h4, 8'hA0);
        wr(4'h0, 8'hA0);
        @(posedge clk_sys);
        lockDetect <= 1'b1;
        settle();
        chk({7'h00, irq}, 8'h01);
        rdchk(4'h4, 8'hE0);
        rdchk(4'h0, 8'hEF);
        @(negedge clk_sys);
        chk({7'h00, irq}, 8'h00);
        @(posedge clk_sys);
        lockDetect <= 1'b0;
        settle();
        chk({7'h00, irq}, 8'h01);
        wr(4'h4, 8'h00);
        @(negedge clk_sys);
        chk({7'h00, irq}, 8'h00);
        $display("test interrupts done");
        test_done();
    end
endmodule : tb
